//--- dtc_cfg.svh
// register indices, field positions, reset values and timing counts
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH
// register indices; byte address is four times the index
`define DTC_IDX_LOWER_CTRL   6'h1A
`define DTC_IDX_UPPER_CTRL   6'h1B
`define DTC_IDX_LOWER_PERIOD 6'h1E
`define DTC_IDX_UPPER_PERIOD 6'h1F
`define DTC_IDX_LOWER_PULSE  6'h2E
`define DTC_IDX_UPPER_PULSE  6'h2F
`define DTC_IDX_CONFIG       6'h30
`define DTC_IDX_COUNT        6'h31
// control register fields
`define DTC_FF_BIT           7
`define DTC_CLK_MSB          6
`define DTC_CLK_LSB          4
`define DTC_RUN_BIT          3
`define DTC_MODE_MSB         2
`define DTC_MODE_LSB         0
// config register fields
`define DTC_CFG_DIV_BIT      0
`define DTC_CFG_SLOW_BIT     1
// reset values
`define DTC_CTRL_RESET       8'h00
`define DTC_PERIOD_RESET     8'hFF
`define DTC_PULSE_RESET      8'hFF
// prescaler taps, as powers of two of the source clock
`define DTC_HF_DIV_BITS      11
`define DTC_LF_DIV_BITS      3
// bus answers
`define DTC_RESP_OKAY        2'h0
`define DTC_RESP_SLVERR      2'h2
`endif

//--- dtc_pkg.sv
// types shared by the dual 8-bit timer block
package dtc_pkg;
    // lower channel mode codes
    typedef enum logic [2:0] {
        DTC_LOW_SPLIT   = 3'h0,
        DTC_LOW_CASCADE = 3'h3
    } dtc_lower_mode_type;
    // upper channel mode codes
    typedef enum logic [2:0] {
        DTC_UP_TIMER8  = 3'h0,
        DTC_UP_DIVIDER = 3'h1,
        DTC_UP_PWM8    = 3'h2,
        DTC_UP_RESV    = 3'h3,
        DTC_UP_TIMER16 = 3'h4,
        DTC_UP_WARMUP  = 3'h5,
        DTC_UP_PWM16   = 3'h6
    } dtc_upper_mode_type;
endpackage

//--- dtc_timer.sv
// dual 8-bit timer/counter with cascade and an AXI4-Lite register slave
// What this block does
// - clock field picks prescaled high/low taps
// - slow/sleep: full high clock only for warm-up
// - run bit low stops and clears counter
// - lower mode 000 split, 011 cascade
// - cascade: lower clock, upper run bit
// - pulse width writable live in pwm modes
// - lower period and pulse width reset all ones
// - upper control register resets to zero
// - upper mode field: 011 never runs, bit 2 set runs in cascade only, 101 is warm-up
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "dtc_cfg.svh"
module dtc_timer
    import dtc_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    // oscillator taps and event pin, asynchronous to clock
    input  wire logic        high_freq_clock,
    input  wire logic        low_freq_clock,
    input  wire logic        event_pin,
    // AXI4-Lite write channels
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // register state
    logic [7:0]  lower_timer_control, next_lower_timer_control;
    logic [7:0]  upper_timer_control, next_upper_timer_control;
    logic [7:0]  lower_period_compare, next_lower_period_compare;
    logic [7:0]  upper_period_compare, next_upper_period_compare;
    logic [7:0]  lower_pulse_width, next_lower_pulse_width;
    logic [7:0]  upper_pulse_width, next_upper_pulse_width;
    logic [1:0]  config_bits, next_config_bits;
    // bus state
    logic        next_bvalid, next_rvalid;
    logic [1:0]  next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic        write_take, read_take;
    // counters and prescalers
    logic [7:0]  lower_count, next_lower_count;
    logic [7:0]  upper_count, next_upper_count;
    logic [10:0] hf_div;
    logic [2:0]  lf_div;
    // synchronisers: stage one feeds stage two only
    logic [2:0]  hf_sync, lf_sync, pin_sync;
    logic        hf_edge, lf_edge, pin_edge;
    // decoded control
    logic [2:0]  lower_clock_select, upper_clock_select;
    logic [2:0]  lower_mode_field, upper_mode_field;
    logic        lower_run_bit, upper_run_bit;
    logic        divider_tap_select, slow_power_state;
    logic        cascade, warmup, run_lower, run_upper;
    logic        lower_tick, upper_tick, match16;

    // source tick for one clock field; upper channel adds the pin input
    function automatic logic pick_tick(input logic [2:0]  sel,
                                       input logic        slow,
                                       input logic        div_sel,
                                       input logic        warm,
                                       input logic        is_upper,
                                       input logic        hf_e,
                                       input logic [10:0] hdiv,
                                       input logic        lf_e,
                                       input logic [2:0]  ldiv,
                                       input logic        pin_e);
        logic t;
        t = 1'b0;
        case (sel)
            3'h0: t = (slow || div_sel) ? (lf_e && (&ldiv))
                                        : (hf_e && (&hdiv));
            3'h1: t = !slow && hf_e && (&hdiv[6:0]);
            3'h2: t = !slow && hf_e && (&hdiv[4:0]);
            3'h3: t = !slow && hf_e && (&hdiv[2:0]);
            3'h4: t = lf_e;
            3'h5: t = !slow && hf_e && hdiv[0];
            3'h6: t = hf_e && (!slow || warm);
            3'h7: t = is_upper && pin_e;
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    // field extraction
    assign lower_clock_select = lower_timer_control[`DTC_CLK_MSB:`DTC_CLK_LSB];
    assign upper_clock_select = upper_timer_control[`DTC_CLK_MSB:`DTC_CLK_LSB];
    assign lower_mode_field   = lower_timer_control[`DTC_MODE_MSB:`DTC_MODE_LSB];
    assign upper_mode_field   = upper_timer_control[`DTC_MODE_MSB:`DTC_MODE_LSB];
    assign lower_run_bit      = lower_timer_control[`DTC_RUN_BIT];
    assign upper_run_bit      = upper_timer_control[`DTC_RUN_BIT];
    assign divider_tap_select = config_bits[`DTC_CFG_DIV_BIT];
    assign slow_power_state   = config_bits[`DTC_CFG_SLOW_BIT];

    // edges of the synchronised sources, taken from stages two and three
    assign hf_edge  = hf_sync[1] && !hf_sync[2];
    assign lf_edge  = lf_sync[1] && !lf_sync[2];
    assign pin_edge = pin_sync[1] && !pin_sync[2];

    // mode decode; lower reserved codes and upper 011 never count
    assign cascade = (lower_mode_field == DTC_LOW_CASCADE);
    assign warmup  = cascade
                     && (upper_mode_field == DTC_UP_WARMUP);
    assign run_lower = cascade ? (upper_run_bit && upper_mode_field[2])
                               : ((lower_mode_field == DTC_LOW_SPLIT)
                                  && lower_run_bit);
    assign run_upper = cascade ? run_lower
                               : (upper_run_bit && !upper_mode_field[2]
                                  && (upper_mode_field != DTC_UP_RESV));

    // ticks; in cascade both halves run off the lower clock field
    assign lower_tick = pick_tick(lower_clock_select, slow_power_state,
                                  divider_tap_select, warmup, 1'b0,
                                  hf_edge, hf_div, lf_edge, lf_div,
                                  pin_edge);
    assign upper_tick = pick_tick(upper_clock_select, slow_power_state,
                                  divider_tap_select, 1'b0, 1'b1,
                                  hf_edge, hf_div, lf_edge, lf_div,
                                  pin_edge);
    // warm-up compares only the upper byte
    assign match16 = warmup ? (upper_count == upper_period_compare)
                   : ({upper_count, lower_count}
                      == {upper_period_compare, lower_period_compare});

    // counter next values
    always_comb begin
        next_lower_count = lower_count;
        next_upper_count = upper_count;
        if (!run_lower) begin
            next_lower_count = 8'h00;
        end else if (lower_tick) begin
            if (cascade && match16) begin
                next_lower_count = 8'h00;
                next_upper_count = 8'h00;
            end else if (!cascade && lower_count == lower_period_compare) begin
                next_lower_count = 8'h00;
            end else begin
                next_lower_count = lower_count + 8'h01;
                if (cascade && (&lower_count)) begin
                    next_upper_count = upper_count + 8'h01;
                end
            end
        end
        if (!cascade) begin
            if (!run_upper) begin
                next_upper_count = 8'h00;
            end else if (upper_tick) begin
                next_upper_count = (upper_count == upper_period_compare)
                                 ? 8'h00 : upper_count + 8'h01;
            end
        end else if (!run_lower) begin
            next_upper_count = 8'h00;
        end
    end

    // handshakes: one write and one read outstanding at most
    assign write_take    = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign read_take     = s_axi_arvalid && !s_axi_rvalid;
    assign s_axi_awready = write_take;
    assign s_axi_wready  = write_take;
    assign s_axi_arready = read_take;

    // register and bus next values
    always_comb begin
        next_lower_timer_control  = lower_timer_control;
        next_upper_timer_control  = upper_timer_control;
        next_lower_period_compare = lower_period_compare;
        next_upper_period_compare = upper_period_compare;
        next_lower_pulse_width    = lower_pulse_width;
        next_upper_pulse_width    = upper_pulse_width;
        next_config_bits          = config_bits;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp  = s_axi_bresp;
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rresp  = s_axi_rresp;
        next_rdata  = s_axi_rdata;
        if (write_take) begin
            next_bvalid = 1'b1;
            next_bresp  = `DTC_RESP_OKAY;
            // only byte lane 0 carries register data; the guard rules
            // on live changes are left to software, writes always land
            case (s_axi_awaddr[7:2])
                `DTC_IDX_LOWER_CTRL: if (s_axi_wstrb[0]) begin
                    next_lower_timer_control = s_axi_wdata[7:0];
                end
                `DTC_IDX_UPPER_CTRL: if (s_axi_wstrb[0]) begin
                    next_upper_timer_control = s_axi_wdata[7:0];
                end
                `DTC_IDX_LOWER_PERIOD: if (s_axi_wstrb[0]) begin
                    next_lower_period_compare = s_axi_wdata[7:0];
                end
                `DTC_IDX_UPPER_PERIOD: if (s_axi_wstrb[0]) begin
                    next_upper_period_compare = s_axi_wdata[7:0];
                end
                `DTC_IDX_LOWER_PULSE: if (s_axi_wstrb[0]) begin
                    next_lower_pulse_width = s_axi_wdata[7:0];
                end
                `DTC_IDX_UPPER_PULSE: if (s_axi_wstrb[0]) begin
                    next_upper_pulse_width = s_axi_wdata[7:0];
                end
                `DTC_IDX_CONFIG: if (s_axi_wstrb[0]) begin
                    next_config_bits = s_axi_wdata[1:0];
                end
                `DTC_IDX_COUNT: begin
                    next_bresp = `DTC_RESP_OKAY;  // read-only, write dropped
                end
                default: begin
                    next_bresp = `DTC_RESP_SLVERR;
                end
            endcase
        end
        if (read_take) begin
            next_rvalid = 1'b1;
            next_rresp  = `DTC_RESP_OKAY;
            next_rdata  = 32'h0000_0000;
            case (s_axi_araddr[7:2])
                `DTC_IDX_LOWER_CTRL:   next_rdata[7:0] = lower_timer_control;
                `DTC_IDX_UPPER_CTRL:   next_rdata[7:0] = upper_timer_control;
                `DTC_IDX_LOWER_PERIOD: next_rdata[7:0] = lower_period_compare;
                `DTC_IDX_UPPER_PERIOD: next_rdata[7:0] = upper_period_compare;
                `DTC_IDX_LOWER_PULSE:  next_rdata[7:0] = lower_pulse_width;
                `DTC_IDX_UPPER_PULSE:  next_rdata[7:0] = upper_pulse_width;
                `DTC_IDX_CONFIG:       next_rdata[1:0] = config_bits;
                `DTC_IDX_COUNT:   next_rdata[15:0] = {upper_count, lower_count};
                default:          next_rresp = `DTC_RESP_SLVERR;
            endcase
        end
    end

    // synchronisers and prescalers; raw pins never reach logic directly
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            hf_sync  <= 3'h0;
            lf_sync  <= 3'h0;
            pin_sync <= 3'h0;
            hf_div   <= 11'h000;
            lf_div   <= 3'h0;
        end else begin
            hf_sync  <= {hf_sync[1:0], high_freq_clock};
            lf_sync  <= {lf_sync[1:0], low_freq_clock};
            pin_sync <= {pin_sync[1:0], event_pin};
            if (hf_edge) begin
                hf_div <= hf_div + 11'h001;
            end
            if (lf_edge) begin
                lf_div <= lf_div + 3'h1;
            end
        end
    end

    // state registers
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            lower_timer_control  <= `DTC_CTRL_RESET;
            upper_timer_control  <= `DTC_CTRL_RESET;
            lower_period_compare <= `DTC_PERIOD_RESET;
            upper_period_compare <= `DTC_PERIOD_RESET;
            lower_pulse_width    <= `DTC_PULSE_RESET;
            upper_pulse_width    <= `DTC_PULSE_RESET;
            config_bits          <= 2'h0;
            lower_count          <= 8'h00;
            upper_count          <= 8'h00;
            s_axi_bvalid         <= 1'b0;
            s_axi_bresp          <= `DTC_RESP_OKAY;
            s_axi_rvalid         <= 1'b0;
            s_axi_rresp          <= `DTC_RESP_OKAY;
            s_axi_rdata          <= 32'h0000_0000;
        end else begin
            lower_timer_control  <= next_lower_timer_control;
            upper_timer_control  <= next_upper_timer_control;
            lower_period_compare <= next_lower_period_compare;
            upper_period_compare <= next_upper_period_compare;
            lower_pulse_width    <= next_lower_pulse_width;
            upper_pulse_width    <= next_upper_pulse_width;
            config_bits          <= next_config_bits;
            lower_count          <= next_lower_count;
            upper_count          <= next_upper_count;
            s_axi_bvalid         <= next_bvalid;
            s_axi_bresp          <= next_bresp;
            s_axi_rvalid         <= next_rvalid;
            s_axi_rresp          <= next_rresp;
            s_axi_rdata          <= next_rdata;
        end
    end

    // first cycle after reset, for checking reset values
    logic just_reset;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            just_reset <= 1'b1;
        end else begin
            just_reset <= 1'b0;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    lower_reset_val_a: assert property (just_reset |->
        lower_period_compare == 8'hFF && lower_pulse_width == 8'hFF)
        else $error("lower period or pulse width not all ones");
    upper_reset_val_a: assert property (just_reset |->
        upper_timer_control == 8'h00)
        else $error("upper control not zero after reset");
    stop_clears_a: assert property (!run_lower |=>
        lower_count == 8'h00)
        else $error("stopped lower counter not cleared");
    reserved_clock_a: assert property (
        lower_clock_select == 3'h7 |-> !lower_tick)
        else $error("reserved clock code ticked");
    slow_taps_a: assert property (slow_power_state
        && lower_clock_select inside {3'h1, 3'h2, 3'h3, 3'h5}
        |-> !lower_tick)
        else $error("high clock tap ticked in slow state");
    slow_full_clock_a: assert property (slow_power_state
        && lower_clock_select == 3'h6 && !warmup |-> !lower_tick)
        else $error("full high clock outside warm-up in slow state");
    tap_eight_a: assert property (!slow_power_state
        && lower_clock_select == 3'h3 && lower_tick |->
        hf_div[2:0] == 3'h7)
        else $error("divide by eight tap off phase");
    count_step_a: assert property (run_lower && lower_tick
        && !cascade && lower_count != lower_period_compare |=>
        lower_count == $past(lower_count) + 8'h01)
        else $error("lower counter did not step");
    idle_hold_a: assert property (run_lower && !lower_tick
        |=> lower_count == $past(lower_count))
        else $error("lower counter moved without a tick");
    cascade_carry_a: assert property (cascade && run_lower
        && lower_tick && lower_count == 8'hFF && !match16 |=>
        upper_count == $past(upper_count) + 8'h01)
        else $error("cascade carry lost");
    reserved_mode_a: assert property (
        !(lower_mode_field inside {3'h0, 3'h3}) |-> !run_lower)
        else $error("reserved lower mode runs");
    live_pulse_a: assert property (write_take && s_axi_wstrb[0]
        && s_axi_awaddr[7:2] == `DTC_IDX_LOWER_PULSE |=>
        lower_pulse_width == $past(s_axi_wdata[7:0]))
        else $error("pulse width write lost");
    write_answer_a: assert property (write_take |=>
        s_axi_bvalid && !s_axi_awready)
        else $error("write not answered next cycle");

    cascade_run_c: cover property (cascade && run_lower && lower_tick
        && lower_count == 8'hFF);
    warmup_match_c: cover property (warmup && run_lower && match16);
    split_wrap_c: cover property (!cascade && run_upper && upper_tick
        && upper_count == upper_period_compare);
    unmapped_c: cover property (s_axi_rvalid
        && s_axi_rresp == `DTC_RESP_SLVERR);
endmodule

//--- tb.sv
// self-checking bench for the dual 8-bit timer block over its register bus
`timescale 1ns/10ps
`include "dtc_cfg.svh"
module tb;
    import dtc_pkg::*;
    // byte addresses are four times the register index
    localparam logic [7:0] A_LC = {`DTC_IDX_LOWER_CTRL, 2'b00};
    localparam logic [7:0] A_UC = {`DTC_IDX_UPPER_CTRL, 2'b00};
    localparam logic [7:0] A_LP = {`DTC_IDX_LOWER_PERIOD, 2'b00};
    localparam logic [7:0] A_UP = {`DTC_IDX_UPPER_PERIOD, 2'b00};
    localparam logic [7:0] A_LW = {`DTC_IDX_LOWER_PULSE, 2'b00};
    localparam logic [7:0] A_UW = {`DTC_IDX_UPPER_PULSE, 2'b00};
    localparam logic [7:0] A_CF = {`DTC_IDX_CONFIG, 2'b00};
    localparam logic [7:0] A_CN = {`DTC_IDX_COUNT, 2'b00};
    localparam logic [1:0] OK = `DTC_RESP_OKAY;
    localparam logic [1:0] ERR = `DTC_RESP_SLVERR;
    // clock, reset and count sources
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        hf = 1'b0;
    logic        lf = 1'b0;
    logic        ev = 1'b0;
    // register bus
    logic [7:0]  awaddr = 8'h00;
    logic        awvalid = 1'b0;
    logic        awready;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hF;
    logic        wvalid = 1'b0;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic [7:0]  araddr = 8'h00;
    logic        arvalid = 1'b0;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    int          mismatches = 0;
    int          n_compared = 0;
    // clock field table: code, config, source, edges, expected ticks
    // the last two rows span a whole divider period, so phase does not matter
    logic [2:0]  t_code [10] = '{3'h4, 3'h6, 3'h5, 3'h3, 3'h0, 3'h7,
                                 3'h5, 3'h6, 3'h1, 3'h2};
    logic [1:0]  t_cfg  [10] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h0,
                                 2'h2, 2'h2, 2'h0, 2'h0};
    int          t_src  [10] = '{0, 1, 1, 1, 0, 0, 1, 1, 1, 1};
    int          t_n    [10] = '{8, 8, 8, 16, 16, 8, 8, 8, 128, 32};
    logic [7:0]  t_exp  [10] = '{8'h08, 8'h08, 8'h04, 8'h02, 8'h02, 8'h00,
                                 8'h00, 8'h00, 8'h01, 8'h01};

    dtc_timer dtc_timer_i (
        .clock(clock), .reset(reset),
        .high_freq_clock(hf), .low_freq_clock(lf), .event_pin(ev),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(1'b1)
    );

    always #5 clock = ~clock;

    function automatic logic [31:0] ctl(input logic [2:0] c, input logic r,
                                        input logic [2:0] m);
        return {24'h0, 1'b0, c, r, m};
    endfunction

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // address and data offered together, released at the taking edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        @(posedge clock);
        while ((awready & wready) !== 1'b1 && n < 100) begin
            @(posedge clock);
            n++;
        end
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        @(posedge clock);
        while (bvalid !== 1'b1 && n < 100) begin
            @(posedge clock);
            n++;
        end
        check("write wait", {31'h0, n >= 100}, 32'h0);
        check("bresp", {30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        @(posedge clock);
        while (arready !== 1'b1 && n < 100) begin
            @(posedge clock);
            n++;
        end
        arvalid <= 1'b0;
        @(posedge clock);
        while (rvalid !== 1'b1 && n < 100) begin
            @(posedge clock);
            n++;
        end
        check("read wait", {31'h0, n >= 100}, 32'h0);
        check("rdata", rdata, ed);
        check("rresp", {30'h0, rresp}, {30'h0, er});
    endtask

    // each source edge is held long enough to pass the three-flop sync
    task automatic pulses(input int src, input int n);
        repeat (n) begin
            if (src == 0) lf <= 1'b1;
            else if (src == 1) hf <= 1'b1;
            else ev <= 1'b1;
            repeat (3) @(posedge clock);
            if (src == 0) lf <= 1'b0;
            else if (src == 1) hf <= 1'b0;
            else ev <= 1'b0;
            repeat (3) @(posedge clock);
        end
        repeat (6) @(posedge clock);
    endtask

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // watchdog: the sequence needs well under 10000 cycles
    initial begin
        #300us;
        mismatches++;
        stop_test();
    end

    initial begin
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        rd(A_LC, 32'h00, OK);
        rd(A_UC, 32'h00, OK);
        rd(A_LP, 32'hFF, OK);
        rd(A_LW, 32'hFF, OK);
        rd(A_UP, 32'hFF, OK);
        rd(A_UW, 32'hFF, OK);
        rd(A_CN, 32'h00, OK);
        $display("test reset values done");
        rd(8'h00, 32'h0, ERR);
        wr(8'h00, 32'hFF, ERR);
        wr(A_CN, 32'h1234, OK);
        rd(A_CN, 32'h0, OK);
        wr(A_UC, 32'hA5, OK);
        rd(A_UC, 32'hA5, OK);
        wr(A_UC, 32'h00, OK);
        wr(A_UP, 32'h3C, OK);
        rd(A_UP, 32'h3C, OK);
        wr(A_UP, 32'hFF, OK);
        // a write without byte lane 0 is answered but changes nothing
        wstrb <= 4'h0;
        wr(A_UP, 32'h11, OK);
        wstrb <= 4'hF;
        rd(A_UP, 32'hFF, OK);
        $display("test register access done");
        // every clock code (code 0 on its low tap only), also the slow state and the reserved code
        for (int i = 0; i < 10; i++) begin
            wr(A_CF, {30'h0, t_cfg[i]}, OK);
            wr(A_LC, ctl(t_code[i], 1'b1, 3'h0), OK);
            pulses(t_src[i], t_n[i]);
            rd(A_CN, {24'h0, t_exp[i]}, OK);
            wr(A_LC, ctl(t_code[i], 1'b0, 3'h0), OK);
            rd(A_CN, 32'h0, OK);
        end
        wr(A_CF, 32'h0, OK);
        $display("test clock taps done");
        // a period match clears the counter, so 8 ticks end at 3
        wr(A_LP, 32'h04, OK);
        wr(A_LC, ctl(3'h4, 1'b1, 3'h0), OK);
        pulses(0, 8);
        rd(A_CN, 32'h03, OK);
        wr(A_LC, ctl(3'h4, 1'b0, 3'h0), OK);
        wr(A_LP, 32'hFF, OK);
        $display("test period match done");
        // cascade in 16-bit pwm: lower source, upper run bit, carry into
        // upper byte; pwm is the only mode where a live pulse write is legal
        wr(A_LC, ctl(3'h4, 1'b0, 3'h3), OK);
        wr(A_UC, ctl(3'h0, 1'b1, 3'h6), OK);
        pulses(0, 264);
        rd(A_CN, 32'h0108, OK);
        wr(A_LW, 32'h5A, OK);
        rd(A_LW, 32'h5A, OK);
        wr(A_UC, ctl(3'h0, 1'b0, 3'h6), OK);
        rd(A_CN, 32'h0, OK);
        wr(A_LC, 32'h0, OK);
        $display("test cascade done");
        // warm-up in slow state: full high clock, upper byte match only
        wr(A_CF, 32'h2, OK);
        wr(A_UP, 32'h01, OK);
        wr(A_LC, ctl(3'h6, 1'b0, 3'h3), OK);
        wr(A_UC, ctl(3'h0, 1'b1, 3'h5), OK);
        pulses(1, 260);
        rd(A_CN, 32'h0003, OK);
        wr(A_UC, ctl(3'h0, 1'b0, 3'h5), OK);
        rd(A_CN, 32'h0, OK);
        wr(A_UP, 32'hFF, OK);
        wr(A_LC, 32'h0, OK);
        wr(A_CF, 32'h0, OK);
        $display("test warm-up done");
        // upper channel counting pin events alone
        wr(A_UC, ctl(3'h7, 1'b1, 3'h0), OK);
        pulses(2, 8);
        rd(A_CN, 32'h0800, OK);
        wr(A_UC, ctl(3'h7, 1'b0, 3'h0), OK);
        $display("test event count done");
        stop_test();
    end
endmodule
